// file: hdl/host_link_consts.svh
// Constants of the serial command link: framing, timing, register map.
// Assumes a single core clock; included by the package and both ends.
`ifndef HOST_LINK_CONSTS_SVH
`define HOST_LINK_CONSTS_SVH

`define CLK_HZ 200000000
`define BAUD_RATE 9600
`define BIT_CYCLES (`CLK_HZ / `BAUD_RATE)
`define LONG_OP_MS 5
`define LONG_OP_CYCLES (`LONG_OP_MS * (`CLK_HZ / 1000))

// Frame fields
`define F_CHK_HI 31
`define F_CHK_LO 28
`define F_CE 27
`define F_RW 24
`define F_STAT_HI 25
`define F_STAT_LO 24
`define F_REG_HI 23
`define F_REG_LO 16

// Response status codes
`define ST_OK 2'h0
`define ST_XE 2'h1
`define ST_PEND 2'h2

// Module register numbers
`define REG_PENDING_POLL 8'h00
`define REG_FATAL_STATUS 8'h20
`define REG_SVC_REQ_CFG 8'h28
`define REG_LONG_OP 8'h30
`define REG_VENDOR_BASE 8'h80
`define REG_DEVICE_BASE 8'h20

// Host command port offsets
`define H_CMD 8'h00
`define H_STAT 8'h04
`define H_RSP 8'h08

`endif

// file: hdl/host_link_pkg.sv
// Types shared by both ends of the serial command link.
// Assumes the constants header is on the include path.
`include "host_link_consts.svh"
package host_link_pkg;
   typedef logic [31:0] frame_t;
   typedef logic [15:0] word_t;
   typedef logic [7:0] regnum_t;
   typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage

// file: hdl/host_link_if.sv
// Two serial lines between host controller and module.
// Assumes both ends share core_clk; the bench supplies it.
`timescale 1ns/1ps
interface host_link_if;
   logic cmd_line;
   logic rsp_line;
   modport device (input cmd_line, output rsp_line);
   modport host (output cmd_line, input rsp_line);
endinterface

// file: hdl/link_module_end.sv
// Module end: serial character engines and command interpreter.
// Assumes idle-high lines and a host that frames commands correctly.
`timescale 1ns/1ps
`include "host_link_consts.svh"

////////////////////////////////////////////////////////////////////////
module serial_char_tx #(
   parameter int BIT_CYCLES = `BIT_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready,
   output logic line
);
   import host_link_pkg::*;
   logic [9:0] sh_r;
   logic [3:0] bits_r;
   logic [15:0] cnt_r;
   wire bit_end = (cnt_r == 16'(BIT_CYCLES - 1));
   assign tx_ready = (bits_r == 4'h0);
   assign line = sh_r[0];
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sh_r <= 10'h3FF;
         bits_r <= 4'h0;
         cnt_r <= 16'h0000;
      end else if (tx_ready && tx_valid) begin
         sh_r <= {1'b1, tx_data, 1'b0};
         bits_r <= 4'hA;
         cnt_r <= 16'h0000;
      end else if (!tx_ready) begin
         cnt_r <= bit_end ? 16'h0000 : cnt_r + 16'h0001;
         if (bit_end) begin
            sh_r <= {1'b1, sh_r[9:1]};
            bits_r <= bits_r - 4'h1;
         end
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////
module serial_char_rx #(
   parameter int BIT_CYCLES = `BIT_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic line,
   output logic rx_valid,
   output logic rx_bad,
   output logic [7:0] rx_data
);
   import host_link_pkg::*;
   logic sync1_r, sync2_r;
   rx_state_t state_r;
   logic [15:0] cnt_r;
   logic [2:0] bitn_r;
   logic [7:0] sh_r;
   logic valid_r, bad_r;
   wire half = (cnt_r == 16'(BIT_CYCLES / 2 - 1));
   wire full = (cnt_r == 16'(BIT_CYCLES - 1));
   assign rx_valid = valid_r;
   assign rx_bad = bad_r;
   assign rx_data = sh_r;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sync1_r <= 1'b1;
         sync2_r <= 1'b1;
         state_r <= RX_IDLE;
         cnt_r <= 16'h0000;
         bitn_r <= 3'h0;
         sh_r <= 8'h00;
         valid_r <= 1'b0;
         bad_r <= 1'b0;
      end else begin
         sync1_r <= line;
         sync2_r <= sync1_r;
         valid_r <= 1'b0;
         bad_r <= 1'b0;
         cnt_r <= cnt_r + 16'h0001;
         case (state_r)
            RX_IDLE: begin
               cnt_r <= 16'h0000;
               if (!sync2_r) state_r <= RX_START;
            end
            RX_START: if (half) begin
               cnt_r <= 16'h0000;
               state_r <= sync2_r ? RX_IDLE : RX_DATA; // Glitch filter
            end
            RX_DATA: if (full) begin
               cnt_r <= 16'h0000;
               sh_r <= {sync2_r, sh_r[7:1]};
               bitn_r <= bitn_r + 3'h1;
               if (bitn_r == 3'h7) state_r <= RX_STOP;
            end
            RX_STOP: if (full) begin
               valid_r <= sync2_r;
               bad_r <= !sync2_r;
               state_r <= RX_IDLE;
            end
            default: state_r <= RX_IDLE;
         endcase
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////
module link_module_end #(
   parameter int BIT_CYCLES = `BIT_CYCLES,
   parameter int LONG_OP_CYCLES = `LONG_OP_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst_n,
   host_link_if.device link,
   output logic service_request,
   output logic busy_pending
);
   import host_link_pkg::*;
   logic [7:0] rx_byte;
   logic rx_valid, rx_bad, tx_ready;
   frame_t frame_r, rsp_r;
   logic [1:0] idx_r;
   logic [2:0] txn_r;
   logic got_r, ce_r, pend_r, err_r, svc_r, svc_en_r, fail_r;
   word_t fatal_r;
   logic [31:0] pend_cnt_r;
   word_t mem_r [0:255];
   wire tx_go = (txn_r != 3'h0) && tx_ready;

   serial_char_rx #(.BIT_CYCLES(BIT_CYCLES)) rx_i (
      .core_clk(core_clk), .rst_n(rst_n), .line(link.cmd_line),
      .rx_valid(rx_valid), .rx_bad(rx_bad), .rx_data(rx_byte));
   serial_char_tx #(.BIT_CYCLES(BIT_CYCLES)) tx_i (
      .core_clk(core_clk), .rst_n(rst_n), .tx_valid(tx_go),
      .tx_data(rsp_r[31:24]), .tx_ready(tx_ready), .line(link.rsp_line));

   ////////////////////////////////////////////////////////////////////
   // Decode of a complete received frame
   wire [3:0] par = frame_r[31:28] ^ frame_r[27:24] ^ frame_r[23:20]
      ^ frame_r[19:16] ^ frame_r[15:12] ^ frame_r[11:8] ^ frame_r[7:4]
      ^ frame_r[3:0];
   wire chk_ok = (par == 4'h0);
   wire exec = got_r && chk_ok;
   wire drop = got_r && !chk_ok;
   wire is_wr = frame_r[`F_RW];
   regnum_t reg_n;
   assign reg_n = frame_r[`F_REG_HI:`F_REG_LO];
   word_t dat;
   assign dat = frame_r[15:0];
   wire in_vendor = (reg_n >= `REG_VENDOR_BASE);
   wire in_device = !in_vendor && (reg_n >= `REG_DEVICE_BASE);
   wire ro_hit = (reg_n == `REG_FATAL_STATUS) && in_device;
   wire long_hit = (reg_n == `REG_LONG_OP);
   wire long_go = exec && is_wr && long_hit && !pend_r;
   wire poll_rd = exec && !is_wr && (reg_n == `REG_PENDING_POLL);
   wire pend_done = pend_r && (pend_cnt_r == 32'h0);
   wire [1:0] st = (is_wr && ro_hit) || (is_wr && long_hit && pend_r)
      ? `ST_XE : (long_go ? `ST_PEND : `ST_OK);
   word_t rd_val;
   assign rd_val = (reg_n == `REG_PENDING_POLL) ?
      {14'h0000, err_r, pend_r} :
      (reg_n == `REG_FATAL_STATUS) ? fatal_r : mem_r[reg_n];
   word_t rsp_dat;
   assign rsp_dat = is_wr ? dat : rd_val;
   wire [25:0] rsp26 = {st, reg_n, rsp_dat};
   wire ce_now = ce_r || rx_bad;
   wire [3:0] rpar = {ce_now, 1'b0, rsp26[25:24]} ^ rsp26[23:20]
      ^ rsp26[19:16] ^ rsp26[15:12] ^ rsp26[11:8] ^ rsp26[7:4]
      ^ rsp26[3:0];

   assign service_request = svc_r;
   assign busy_pending = pend_r;

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         frame_r <= 32'h0000_0000;
         idx_r <= 2'h0;
         got_r <= 1'b0;
      end else begin
         got_r <= rx_valid && (idx_r == 2'h3);
         if (rx_valid) begin
            frame_r <= {frame_r[23:0], rx_byte};
            idx_r <= idx_r + 2'h1;
         end else if (rx_bad) begin
            idx_r <= 2'h0; // Resync on a framing fault
         end
      end
   end

   // Response goes out whole before the next one; host waits for it
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rsp_r <= 32'h0000_0000;
         txn_r <= 3'h0;
         ce_r <= 1'b0;
      end else if (exec) begin
         rsp_r <= {rpar, ce_now, 1'b0, rsp26};
         txn_r <= 3'h4;
         ce_r <= rx_bad;
      end else begin
         if (drop || rx_bad) ce_r <= 1'b1;
         if (tx_go) begin
            rsp_r <= {rsp_r[23:0], 8'h00};
            txn_r <= txn_r - 3'h1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (exec && is_wr && !ro_hit && !(long_hit && pend_r))
         mem_r[reg_n] <= dat;
   end

   // Long operation runs beside normal command traffic
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pend_r <= 1'b0;
         pend_cnt_r <= 32'h0;
         fail_r <= 1'b0;
         err_r <= 1'b0;
         fatal_r <= 16'h0000;
         svc_en_r <= 1'b0;
         svc_r <= 1'b0;
      end else begin
         if (long_go) begin
            pend_r <= 1'b1;
            pend_cnt_r <= 32'(LONG_OP_CYCLES - 1);
            fail_r <= dat[15];
         end else if (pend_r) begin
            pend_cnt_r <= pend_cnt_r - 32'h1;
            if (pend_done) pend_r <= 1'b0;
         end
         if (exec && is_wr && reg_n == `REG_SVC_REQ_CFG) svc_en_r <= dat[0];
         if (exec && is_wr && reg_n == `REG_PENDING_POLL) err_r <= 1'b0;
         if (pend_done && fail_r) begin
            err_r <= 1'b1;
            fatal_r[0] <= 1'b1;
         end
         if (pend_done && fail_r && svc_en_r) svc_r <= 1'b1;
         else if (poll_rd) svc_r <= 1'b0;
      end
   end
endmodule

// file: hdl/link_host_end.sv
// Host end: frames commands from a register port, checks responses.
// Assumes the character engines of the module end file are compiled.
`timescale 1ns/1ps
`include "host_link_consts.svh"
module link_host_end #(
   parameter int BIT_CYCLES = `BIT_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst_n,
   host_link_if.host link,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata
);
   import host_link_pkg::*;
   logic [7:0] rx_byte;
   logic rx_valid, rx_bad, tx_ready;
   frame_t cmd_r, rsp_r;
   logic [2:0] txn_r;
   logic [1:0] idx_r;
   logic busy_r, done_r, rsp_err_r;
   logic [31:0] rdata_r;
   wire tx_go = (txn_r != 3'h0) && tx_ready;

   serial_char_rx #(.BIT_CYCLES(BIT_CYCLES)) rx_i (
      .core_clk(core_clk), .rst_n(rst_n), .line(link.rsp_line),
      .rx_valid(rx_valid), .rx_bad(rx_bad), .rx_data(rx_byte));
   serial_char_tx #(.BIT_CYCLES(BIT_CYCLES)) tx_i (
      .core_clk(core_clk), .rst_n(rst_n), .tx_valid(tx_go),
      .tx_data(cmd_r[31:24]), .tx_ready(tx_ready), .line(link.cmd_line));

   ////////////////////////////////////////////////////////////////////
   wire start = wr && (addr == `H_CMD) && !busy_r;
   wire [27:0] cmd28 = {3'h0, wdata[24:0]};
   wire [3:0] cpar = cmd28[27:24] ^ cmd28[23:20] ^ cmd28[19:16]
      ^ cmd28[15:12] ^ cmd28[11:8] ^ cmd28[7:4] ^ cmd28[3:0];
   frame_t rsp_nxt;
   assign rsp_nxt = {rsp_r[23:0], rx_byte};
   wire [3:0] rpar = rsp_nxt[31:28] ^ rsp_nxt[27:24] ^ rsp_nxt[23:20]
      ^ rsp_nxt[19:16] ^ rsp_nxt[15:12] ^ rsp_nxt[11:8] ^ rsp_nxt[7:4]
      ^ rsp_nxt[3:0];
   wire last = rx_valid && (idx_r == 2'h3);
   wire [31:0] rd_mux = (addr == `H_STAT) ?
      {29'h0, rsp_err_r, done_r, busy_r} :
      (addr == `H_RSP) ? rsp_r : 32'h0000_0000;
   assign rdata = rdata_r;

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cmd_r <= 32'h0000_0000;
         txn_r <= 3'h0;
      end else if (start) begin
         cmd_r <= {cpar, cmd28};
         txn_r <= 3'h4;
      end else if (tx_go) begin
         cmd_r <= {cmd_r[23:0], 8'h00};
         txn_r <= txn_r - 3'h1;
      end
   end

   // Busy ends only on a full response; poll or enable the request line
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rsp_r <= 32'h0000_0000;
         idx_r <= 2'h0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         rsp_err_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
      end else begin
         rdata_r <= rd ? rd_mux : 32'h0000_0000;
         if (rx_valid) begin
            rsp_r <= rsp_nxt;
            idx_r <= idx_r + 2'h1;
         end else if (rx_bad) begin
            idx_r <= 2'h0;
         end
         if (start) begin
            busy_r <= 1'b1;
            done_r <= 1'b0;
         end else if (last) begin
            busy_r <= 1'b0;
            done_r <= 1'b1;
            rsp_err_r <= (rpar != 4'h0) || rsp_nxt[`F_CE];
         end
      end
   end
endmodule

// file: test/host_link_chk.sv
// Assertions on the two serial lines and the module status outputs.
// Assumes one core clock; placed beside the interface joining both ends.
`timescale 1ns/1ps
module host_link_chk #(
   parameter int BIT_CYCLES = 16,
   parameter int LONG_OP_CYCLES = 50
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic cmd_line,
   input wire logic rsp_line,
   input wire logic service_request,
   input wire logic busy_pending
);
   logic [1:0] ln;
   logic [1:0] prev_r;
   int run_r [2];
   int pend_r;
   assign ln = {rsp_line, cmd_line};
   ////////////////////////////////////////////////////////////////////
   // Run lengths per line; reset preloads one bit time so the
   // first start bit after release is not flagged
   always_ff @(posedge core_clk) begin
      prev_r <= rst_n ? ln : 2'h3;
      pend_r <= busy_pending ? pend_r + 1 : 0;
      for (int i = 0; i < 2; i++) begin
         if (!rst_n || ln[i] != prev_r[i]) begin
            run_r[i] <= rst_n ? 1 : BIT_CYCLES;
         end else if (run_r[i] < 32'h00100000) begin
            run_r[i] <= run_r[i] + 1;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   reset_idle_a:
   assert property (disable iff (1'b0) !rst_n |=> cmd_line && rsp_line
      && !service_request && !busy_pending) else $error("reset levels");
   cmd_bits_a:
   assert property (cmd_line && !prev_r[0] |-> run_r[0] % BIT_CYCLES == 0
      && run_r[0] <= 9 * BIT_CYCLES) else $error("cmd low run");
   rsp_bits_a:
   assert property (rsp_line && !prev_r[1] |-> run_r[1] % BIT_CYCLES == 0
      && run_r[1] <= 9 * BIT_CYCLES) else $error("rsp low run");
   cmd_stop_a:
   assert property (!cmd_line && prev_r[0] |-> run_r[0] >= BIT_CYCLES)
      else $error("cmd stop short");
   rsp_stop_a:
   assert property (!rsp_line && prev_r[1] |-> run_r[1] >= BIT_CYCLES)
      else $error("rsp stop short");
   reply_after_a:
   assert property (!cmd_line |-> rsp_line) else $error("reply overlap");
   host_waits_a:
   assert property (!rsp_line |-> cmd_line) else $error("cmd overlap");
   svc_at_end_a:
   assert property ($rose(service_request) |-> !busy_pending)
      else $error("request while pending");
   pend_len_a:
   assert property ($fell(busy_pending) |-> pend_r inside
      {[LONG_OP_CYCLES - 2:LONG_OP_CYCLES + 2]}) else $error("pend len");
   pend_start_a:
   assert property ($rose(busy_pending) |-> cmd_line)
      else $error("pend mid frame");
endmodule

// file: test/host_command_link_test.sv
// Bench joining host and module ends over the serial link.
// Assumes design files, header and checker are compiled first.
`timescale 1ns/1ps
`include "host_link_consts.svh"
module host_command_link_test;
   import host_link_pkg::*;
   localparam int BC = 16;
   localparam int LC = 4000;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic [31:0] rdata;
   logic service_request;
   logic busy_pending;
   int errors = 0;
   int cmp_count = 0;
   host_link_if link();
   always #2.5 core_clk = ~core_clk;
   link_host_end #(.BIT_CYCLES(BC)) link_host_end_inst (
      .core_clk(core_clk), .rst_n(rst_n), .link(link), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   link_module_end #(.BIT_CYCLES(BC), .LONG_OP_CYCLES(LC))
      link_module_end_inst (.core_clk(core_clk), .rst_n(rst_n),
      .link(link), .service_request(service_request),
      .busy_pending(busy_pending));
   host_link_chk #(.BIT_CYCLES(BC), .LONG_OP_CYCLES(LC)) host_link_chk_inst (
      .core_clk(core_clk), .rst_n(rst_n), .cmd_line(link.cmd_line),
      .rsp_line(link.rsp_line), .service_request(service_request),
      .busy_pending(busy_pending));
   ////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      if (errors == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic hw(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask
   task automatic hr(input logic [7:0] a, output logic [31:0] v);
      @(posedge core_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   function automatic frame_t mk(input logic [27:0] b);
      logic [3:0] x;
      x = 4'h0;
      for (int i = 0; i < 7; i++) x ^= b[i*4 +: 4];
      return {x, b};
   endfunction
   // Samples mid-bit, so a skewed bit edge still reads cleanly
   task automatic grab(input bit sel, output frame_t f);
      logic [9:0] ch;
      int n;
      for (int c = 0; c < 4; c++) begin
         n = 0;
         while ((sel ? link.rsp_line : link.cmd_line) !== 1'b0) begin
            tick(1);
            #1;
            n++;
            if (n > 4 * BC) begin
               check(32'h00000000, 32'h00000001);
               conclude();
            end
         end
         tick(BC / 2);
         for (int b = 0; b < 10; b++) begin
            ch[b] = sel ? link.rsp_line : link.cmd_line;
            if (b < 9) tick(BC);
         end
         check({30'h0, ch[9], ch[0]}, 32'h00000002);
         f = {f[23:0], ch[8:1]};
      end
   endtask
   task automatic xfer(input logic rw, input regnum_t r, input word_t d,
      input logic [1:0] st, input word_t q);
      frame_t f;
      frame_t e;
      int n;
      e = mk({1'b0, 1'b0, st, r, q});
      hw(`H_CMD, {7'h00, rw, r, d});
      // Ignored while busy; the frame check below catches a leak
      hw(`H_CMD, {7'h00, ~rw, ~r, ~d});
      grab(1'b0, f);
      check(f, mk({3'h0, rw, r, d}));
      grab(1'b1, f);
      check(f, e);
      n = 0;
      do begin
         hr(`H_STAT, f);
         n++;
      end while (f[1] !== 1'b1 && n < 100);
      check({29'h0, f[2:0]}, 32'h00000002);
      if (f[1] !== 1'b1) conclude();
      hr(`H_RSP, f);
      check(f, e);
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      regnum_t tbl [5] = '{8'h1F, 8'h20 + 8'h21, 8'h7F, 8'h80, 8'hFF};
      foreach (tbl[i]) xfer(1'b1, tbl[i], {tbl[i], ~tbl[i]}, `ST_OK,
         {tbl[i], ~tbl[i]});
      foreach (tbl[i]) xfer(1'b0, tbl[i], 16'h0000, `ST_OK,
         {tbl[i], ~tbl[i]});
      xfer(1'b1, 8'h41, 16'h4954, `ST_OK, 16'h4954);
      xfer(1'b0, 8'h41, 16'h0000, `ST_OK, 16'h4954);
      xfer(1'b1, 8'h7F, 16'hFFFE, `ST_OK, 16'hFFFE);
      xfer(1'b0, 8'h7F, 16'h0000, `ST_OK, 16'hFFFE);
   endtask
   task automatic t_long();
      int n;
      xfer(1'b1, `REG_SVC_REQ_CFG, 16'h0001, `ST_OK, 16'h0001);
      xfer(1'b1, `REG_LONG_OP, 16'h8000, `ST_PEND, 16'h8000);
      check({31'h0, busy_pending}, 32'h00000001);
      xfer(1'b1, `REG_LONG_OP, 16'h0000, `ST_XE, 16'h0000);
      xfer(1'b0, `REG_PENDING_POLL, 16'h0000, `ST_OK, 16'h0001);
      n = 0;
      while (busy_pending !== 1'b0 && n < LC) begin
         tick(1);
         #1;
         n++;
      end
      check({30'h0, service_request, busy_pending}, 32'h2);
      if (busy_pending !== 1'b0) conclude();
      xfer(1'b0, `REG_PENDING_POLL, 16'h0000, `ST_OK, 16'h0002);
      check({31'h0, service_request}, 32'h00000000);
      xfer(1'b0, `REG_FATAL_STATUS, 16'h0000, `ST_OK, 16'h0001);
      xfer(1'b1, `REG_FATAL_STATUS, 16'h0000, `ST_XE, 16'h0000);
   endtask
   initial begin
      logic [31:0] v;
      tick(12);
      check({28'h0, link.cmd_line, link.rsp_line, service_request,
         busy_pending}, 32'h0000000C);
      rst_n <= 1'b1;
      hr(8'h0C, v);
      check(v, 32'h00000000);
      t_regs();
      t_long();
      conclude();
   end
endmodule
